// >>> adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model
(
  input  wire logic [3:0]  adc_chan_sel,
  input  wire logic [11:0] adc_trial_code,
  input  wire logic [11:0] level [16],
  output logic             cmp_in
);
  // one comparator on the selected channel's level
  // Input sits half a step above its code so a strict compare converts exactly
  assign cmp_in = {level[adc_chan_sel], 1'b1} > {adc_trial_code, 1'b0};
endmodule : adc_analog_model

// >>> adc_sampling_sequencer.sv
`timescale 1ns/1ps
module adc_sampling_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        foc_req,
  input  wire logic [1:0]  foc_kind,
  output logic             foc_result_valid,
  output logic [15:0]      foc_result,
  input  wire logic        t1_req,
  input  wire logic [1:0]  t1_kind,
  output logic             t1_result_valid,
  output logic [15:0]      t1_result,
  input  wire logic        cmp_in,
  output logic [3:0]       adc_chan_sel,
  output logic             adc_sample,
  output logic [11:0]      adc_trial_code,
  output logic             ratio_select
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LAUNCH = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;

  seq_state_t          state_q;
  logic [7:0]          cr_q;
  logic [15:0]         channel_enable_mask_q;
  logic [7:0]          sample_cycle_config_q;
  logic [3:0]          scyc_dac_q;
  logic [3:0]          scyc_ph_q;
  logic [6:0]          trig_cfg_q;
  logic [15:0]         channel_result_q [NUM_CH];
  logic [15:0]         pending_q;
  logic                foc_pend_q;
  logic [1:0]          foc_kind_q;
  logic                t1_pend_q;
  logic [1:0]          t1_kind_q;
  logic                job_trig_q;
  logic                job_foc_q;
  logic [CH_W-1:0]     job_ch_q;
  logic                cmp_meta_q;
  logic                cmp_sync_q;
  logic                wr_pend_q;
  logic [15:0]         wr_idx_q;
  logic                tick;
  logic                core_busy;
  logic                core_done;
  logic [CODE_W-1:0]   core_code;
  logic [CH_W-1:0]     next_ch;
  logic                next_found;
  logic [CH_W-1:0]     foc_ch;
  logic [CH_W-1:0]     t1_ch;
  logic                t1_kind_ok;
  logic [3:0]          samp_field;
  logic [15:0]         addr_idx;
  logic                addr_ok;
  logic [31:0]         rd_data;
  logic                start_wr;
  logic                done_clr;
  logic                pass_end;
  logic                core_start;

  assign addr_idx = haddr[17:2];
  assign addr_ok  = hsel && htrans[1] && hready;

  // Pin input crosses into hclk through two flops
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end

  conv_tick_gen u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  sar_engine u_sar (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .tick       (tick),
    .start      (core_start),
    .chan       (job_ch_q),
    .samp_ticks (scyc_ticks(samp_field)),
    .cmp_hi     (cmp_sync_q),
    .busy       (core_busy),
    .done       (core_done),
    .code       (core_code),
    .chan_sel   (adc_chan_sel),
    .sampling   (adc_sample),
    .trial      (adc_trial_code)
  );

  // lowest enabled channel still to do
  always_comb
  begin
    next_ch    = '0;
    next_found = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (pending_q[i])
      begin
        next_ch    = CH_W'(i);
        next_found = 1'b1;
      end
  end

  // bus voltage on 2 or 15; phase A current on 4 or 0 by shunt mode, B and C fixed
  always_comb
    unique case (foc_kind_q)
      FOC_IA:  foc_ch = (trig_cfg_q[TC_SHUNT_LO +: 2] == SHUNT_SINGLE) ? 4'd4 : 4'd0;
      FOC_IB:  foc_ch = 4'd1;
      FOC_IC:  foc_ch = 4'd4;
      default: foc_ch = trig_cfg_q[TC_BUSV_SEL] ? 4'd15 : 4'd2;
    endcase

  always_comb
    unique case (t1_kind_q)
      T1_IBUS: t1_ch = 4'd4;
      T1_U:    t1_ch = 4'd10;
      T1_V:    t1_ch = trig_cfg_q[TC_PH_MAP] ? 4'd12 : 4'd9;
      default: t1_ch = trig_cfg_q[TC_PH_MAP] ? 4'd13 : 4'd8;
    endcase

  // phase samples only when the converter feeds position detection
  assign t1_kind_ok = (t1_kind == T1_IBUS) || trig_cfg_q[TC_POS_SRC];

  // sampling field for the channel being launched
  always_comb
    unique case (job_ch_q)
      4'd0, 4'd1, 4'd3, 4'd4, 4'd5, 4'd10, 4'd12: samp_field = sample_cycle_config_q[3:0];
      4'd6, 4'd7, 4'd14:                          samp_field = sample_cycle_config_q[7:4];
      4'd2, 4'd15:                                samp_field = scyc_ph_q;
      default:                                    samp_field = scyc_dac_q;
    endcase

  // Write decode; start needs a non-empty mask
  assign start_wr   = wr_pend_q && (wr_idx_q == IDX_CR) && hwdata[CR_BUSY] && cr_q[CR_ENABLE] &&
                      (channel_enable_mask_q != 16'h0000);
  assign done_clr   = wr_pend_q && (wr_idx_q == IDX_CR) && !hwdata[CR_DONE];
  assign core_start = (state_q == ST_LAUNCH);
  // The finishing channel's pending bit only drops at this same edge, so mask it out
  assign pass_end   = core_done && !job_trig_q && ((pending_q & ~(16'h0001 << job_ch_q)) == 16'h0000);

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= addr_idx;
      if (addr_ok && !hwrite)
        hrdata <= rd_data;
    end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_data = '0;
    if (addr_idx >= IDX_RES_BASE && addr_idx <= IDX_RES_LAST)
      // unused bits already zero in the stored word
      rd_data = addr_idx[0] ? {24'h0, channel_result_q[4'(addr_idx[4:1] - 4'hc)][7:0]}
                            : {24'h0, channel_result_q[4'(addr_idx[4:1] - 4'hc)][15:8]};
    else
      unique case (addr_idx)
        IDX_CR:       rd_data = {24'h0, cr_q[7:5], 2'b00, cr_q[2:0]};
        IDX_MASKH:    rd_data = {24'h0, channel_enable_mask_q[15:8]};
        IDX_MASKL:    rd_data = {24'h0, channel_enable_mask_q[7:0]};
        IDX_SCYC:     rd_data = {24'h0, sample_cycle_config_q};
        IDX_DAC_CR:   rd_data = {26'h0, scyc_dac_q, 2'b00};
        IDX_PH_SEL2:  rd_data = {26'h0, scyc_ph_q, 2'b00};
        IDX_TRIG_CFG: rd_data = {25'h0, trig_cfg_q};
        default:      rd_data = '0;
      endcase
  end

  // Configuration registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      channel_enable_mask_q <= MASK_RST;
      sample_cycle_config_q <= SCYC_RST;
      scyc_dac_q            <= SCYC_DAC_RST;
      scyc_ph_q             <= SCYC_PH_RST;
      trig_cfg_q            <= TRIG_RST;
    end
    else if (wr_pend_q)
      unique case (wr_idx_q)
        IDX_MASKH:    channel_enable_mask_q[15:8] <= hwdata[7:0];
        IDX_MASKL:    channel_enable_mask_q[7:0]  <= hwdata[7:0];
        IDX_SCYC:     sample_cycle_config_q       <= hwdata[7:0];
        IDX_DAC_CR:   scyc_dac_q                  <= hwdata[5:2];
        IDX_PH_SEL2:  scyc_ph_q                   <= hwdata[5:2];
        IDX_TRIG_CFG: trig_cfg_q                  <= hwdata[6:0];
        default:      ;
      endcase

  // Control register; busy and done are owned by hardware
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cr_q <= CR_RST;
    else
    begin
      if (wr_pend_q && wr_idx_q == IDX_CR)
      begin
        cr_q[CR_ENABLE] <= hwdata[CR_ENABLE];
        cr_q[CR_RATIO]  <= hwdata[CR_RATIO];
        cr_q[CR_ALIGN]  <= hwdata[CR_ALIGN];
        cr_q[CR_IE]     <= hwdata[CR_IE];
      end
      // busy from start until the last enabled channel is stored
      if (start_wr)
        cr_q[CR_BUSY] <= 1'b1;
      else if (pass_end || !cr_q[CR_ENABLE])
        cr_q[CR_BUSY] <= 1'b0;
      // set wins over a clearing write
      if (pass_end)
        cr_q[CR_DONE] <= 1'b1;
      else if (done_clr)
        cr_q[CR_DONE] <= 1'b0;
    end

  // Trigger requests held until served; disabled engines are ignored
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      foc_pend_q <= 1'b0;
      foc_kind_q <= 2'h0;
      t1_pend_q  <= 1'b0;
      t1_kind_q  <= 2'h0;
    end
    else
    begin
      if (foc_req && trig_cfg_q[TC_FOC_EN] && !foc_pend_q)
      begin
        foc_pend_q <= 1'b1;
        foc_kind_q <= foc_kind;
      end
      else if (state_q == ST_IDLE && foc_pend_q && cr_q[CR_ENABLE])
        foc_pend_q <= 1'b0;
      if (t1_req && trig_cfg_q[TC_T1_EN] && t1_kind_ok && !t1_pend_q)
      begin
        t1_pend_q <= 1'b1;
        t1_kind_q <= t1_kind;
      end
      else if (state_q == ST_IDLE && t1_pend_q && !foc_pend_q && cr_q[CR_ENABLE])
        t1_pend_q <= 1'b0;
    end

  // Job scheduler: triggered first, then lowest pending sequential channel
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state_q    <= ST_IDLE;
      job_trig_q <= 1'b0;
      job_foc_q  <= 1'b0;
      job_ch_q   <= '0;
      pending_q  <= '0;
    end
    else
    begin
      // snapshot of the enabled channels for this pass
      if (start_wr && !cr_q[CR_BUSY])
        pending_q <= channel_enable_mask_q;
      else if (!cr_q[CR_ENABLE])
        pending_q <= '0;
      unique case (state_q)
        ST_IDLE:
          if (cr_q[CR_ENABLE] && (foc_pend_q || t1_pend_q))
          begin
            job_trig_q <= 1'b1;
            job_foc_q  <= foc_pend_q;
            job_ch_q   <= foc_pend_q ? foc_ch : t1_ch;
            state_q    <= ST_LAUNCH;
          end
          else if (cr_q[CR_BUSY] && next_found)
          begin
            job_trig_q <= 1'b0;
            job_ch_q   <= next_ch;
            state_q    <= ST_LAUNCH;
          end
        ST_LAUNCH:
          state_q <= ST_WAIT;
        ST_WAIT:
          if (core_done)
          begin
            state_q <= ST_IDLE;
            if (!job_trig_q)
              pending_q[job_ch_q] <= 1'b0;
          end
      endcase
    end

  // sequential results only; alignment per select
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      for (int i = 0; i < NUM_CH; i++)
        channel_result_q[i] <= 16'h0000;
    else if (state_q == ST_WAIT && core_done && !job_trig_q)
      channel_result_q[job_ch_q] <= align_code(core_code, cr_q[CR_ALIGN]);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      foc_result_valid <= 1'b0;
      foc_result       <= 16'h0000;
      t1_result_valid  <= 1'b0;
      t1_result        <= 16'h0000;
      ratio_select     <= 1'b0;
    end
    else
    begin
      ratio_select     <= cr_q[CR_RATIO];
      foc_result_valid <= state_q == ST_WAIT && core_done && job_trig_q && job_foc_q;
      t1_result_valid  <= state_q == ST_WAIT && core_done && job_trig_q && !job_foc_q;
      if (state_q == ST_WAIT && core_done && job_trig_q && job_foc_q)
        foc_result <= align_code(core_code, 1'b1);
      if (state_q == ST_WAIT && core_done && job_trig_q && !job_foc_q)
        t1_result <= align_code(core_code, 1'b1);
    end

endmodule : adc_sampling_sequencer

// >>> adc_sampling_sequencer_bench.sv
`timescale 1ns/1ps
module adc_sampling_sequencer_bench
  import adc_seq_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        foc_req = 1'b0;
  logic [1:0]  foc_kind = 2'h0;
  logic        t1_req = 1'b0;
  logic [1:0]  t1_kind = 2'h0;
  logic        hreadyout, hresp, cmp_in, adc_sample, samp_d, foc_result_valid, t1_result_valid;
  logic [31:0] hrdata;
  logic [15:0] foc_result, t1_result;
  logic [11:0] adc_trial_code;
  logic [3:0]  adc_chan_sel;
  logic [7:0]  rdv;
  logic        ratio_select;
  logic [11:0] lvl [16];
  logic [15:0] res_exp [16];
  logic [3:0]  order_q [$];
  int          error_cnt = 0;
  int          checked = 0;
  int          foc_cnt = 0;

  always #5 hclk = ~hclk;

  // Single slave, so its ready is the bus ready
  adc_sampling_sequencer i_adc_sampling_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .foc_req(foc_req), .foc_kind(foc_kind), .foc_result_valid(foc_result_valid),
    .foc_result(foc_result), .t1_req(t1_req), .t1_kind(t1_kind), .t1_result_valid(t1_result_valid),
    .t1_result(t1_result), .cmp_in(cmp_in), .adc_chan_sel(adc_chan_sel), .adc_sample(adc_sample),
    .adc_trial_code(adc_trial_code), .ratio_select(ratio_select)
  );
  adc_analog_model i_adc_analog_model (
    .adc_chan_sel(adc_chan_sel), .adc_trial_code(adc_trial_code), .level(lvl), .cmp_in(cmp_in)
  );

  // Log the channel of each new sampling window and count motor engine results
  always @(posedge hclk)
  begin
    samp_d <= adc_sample;
    if (adc_sample === 1'b1 && samp_d !== 1'b1)
      order_q.push_back(adc_chan_sel);
    if (foc_result_valid === 1'b1)
      foc_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // A wait that ran out ends the run
  task automatic hang(input string what);
    chk(32'h0, 32'h1, what);
    conclude();
  endtask : hang

  task automatic edge_ready;
    int n;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 20);
    if (hreadyout !== 1'b1)
      hang("bus ready");
  endtask : edge_ready

  // One single word transfer; registers sit at four times their index
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    edge_ready();
    rdv = hrdata[7:0];
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e, input string what);
    xfer(1'b0, idx, 8'h00);
    chk({24'h0, rdv}, {24'h0, e}, what);
  endtask : rd_chk

  // Reset values, an unmapped read and a start with no channel enabled
  task automatic t_idle;
    rd_chk(IDX_CR, CR_RST, "control reset");
    rd_chk(IDX_SCYC, SCYC_RST, "cycles reset");
    rd_chk(IDX_RES_BASE, 8'h00, "result reset");
    rd_chk(16'h0001, 8'h00, "unmapped read");
    wr(IDX_CR, 8'ha0);
    wr(IDX_CR, 8'he0);
    chk({31'h0, ratio_select}, 32'h1, "ratio copy");
    rd_chk(IDX_CR, 8'ha0, "start ignored");
    $display("test idle done");
  endtask : t_idle

  // One hardware request; the level tells which channel was converted
  task automatic tcase(input logic [6:0] cfg, input logic foc, input logic [1:0] kind, input logic [3:0] ch);
    int n;
    wr(IDX_TRIG_CFG, {1'b0, cfg});
    foc_req <= foc;
    t1_req <= !foc;
    foc_kind <= kind;
    t1_kind <= kind;
    @(posedge hclk);
    foc_req <= 1'b0;
    t1_req <= 1'b0;
    n = 0;
    do @(posedge hclk); while ((foc ? foc_result_valid : t1_result_valid) !== 1'b1 && ++n < 2000);
    if ((foc ? foc_result_valid : t1_result_valid) !== 1'b1)
      hang("engine answer");
    chk({16'h0, foc ? foc_result : t1_result}, {17'h0, lvl[ch], 3'h0}, "engine result");
  endtask : tcase

  task automatic t_trig;
    wr(IDX_CR, 8'h80);
    // channels 2 and 15 need a field of at least 3
    wr(IDX_PH_SEL2, 8'h0c);
    tcase(7'h01, 1'b1, FOC_IA, 4'h4);
    tcase(7'h03, 1'b1, FOC_IA, 4'h0);
    tcase(7'h03, 1'b1, FOC_IB, 4'h1);
    tcase(7'h05, 1'b1, FOC_IA, 4'h0);
    tcase(7'h05, 1'b1, FOC_IB, 4'h1);
    tcase(7'h05, 1'b1, FOC_IC, 4'h4);
    tcase(7'h01, 1'b1, 2'h3, 4'h2);
    tcase(7'h09, 1'b1, 2'h3, 4'hf);
    tcase(7'h30, 1'b0, T1_IBUS, 4'h4);
    tcase(7'h30, 1'b0, T1_U, 4'ha);
    tcase(7'h30, 1'b0, T1_V, 4'h9);
    tcase(7'h30, 1'b0, 2'h3, 4'h8);
    tcase(7'h70, 1'b0, T1_V, 4'hc);
    tcase(7'h70, 1'b0, 2'h3, 4'hd);
    rd_chk(IDX_RES_BASE + 16'h3, 8'h00, "no store");
    $display("test triggers done");
  endtask : t_trig

  // Software pass over mask m; mid fires an engine request inside it
  task automatic t_seq(input logic [15:0] m, input logic left, input logic mid);
    int n;
    int k;
    k = foc_cnt;
    wr(IDX_MASKH, m[15:8]);
    wr(IDX_MASKL, m[7:0]);
    wr(IDX_SCYC, 8'h33);
    wr(IDX_PH_SEL2, 8'h0c);
    wr(IDX_CR, {5'h10, left, 2'h0});
    order_q.delete();
    wr(IDX_CR, {5'h18, left, 2'h0});
    xfer(1'b0, IDX_CR, 8'h00);
    chk({31'h0, rdv[CR_BUSY]}, 32'h1, "busy in pass");
    if (mid)
    begin
      foc_kind <= FOC_IB;
      foc_req <= 1'b1;
      @(posedge hclk);
      foc_req <= 1'b0;
    end
    n = 0;
    do xfer(1'b0, IDX_CR, 8'h00); while (rdv[CR_BUSY] !== 1'b0 && ++n < 1000);
    chk({24'h0, rdv}, {24'h0, 5'h10, left, 2'h1}, "pass end");
    if (rdv[CR_BUSY] !== 1'b0)
      conclude();
    chk(32'(foc_cnt - k), {31'h0, mid}, "engine served");
    n = 0;
    for (int c = 0; c < 16; c++)
    begin
      if (m[c])
        res_exp[c] = left ? {1'b0, lvl[c], 3'h0} : {4'h0, lvl[c]};
      rd_chk(IDX_RES_BASE + 16'(2 * c), res_exp[c][15:8], "result high");
      rd_chk(IDX_RES_BASE + 16'(2 * c + 1), res_exp[c][7:0], "result low");
      while (mid && n < order_q.size() && order_q[n] === 4'h1)
        n++;
      if (m[c])
        chk({28'h0, order_q[n++]}, 32'(c), "pass order");
    end
    wr(IDX_CR, {5'h10, left, 2'h0});
    rd_chk(IDX_CR, {5'h10, left, 2'h0}, "flag cleared");
    $display("test pass %h done", m);
  endtask : t_seq

  // Channel 0 at half scale, 15 at full scale, the rest distinct
  initial
  begin
    for (int c = 0; c < 16; c++)
    begin
      lvl[c] = (c == 0) ? 12'h800 : (c == 15) ? 12'hfff : 12'h0d1 * 12'(c);
      res_exp[c] = 16'h0;
    end
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_idle();
    t_trig();
    t_seq(16'h801c, 1'b0, 1'b0);
    t_seq(16'h8001, 1'b1, 1'b0);
    wr(IDX_TRIG_CFG, 8'h03);
    t_seq(16'h0c21, 1'b0, 1'b1);
    conclude();
  end
endmodule : adc_sampling_sequencer_bench

// >>> adc_seq_checker.sv
`timescale 1ns/1ps
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        foc_result_valid,
  input wire logic [15:0] foc_result,
  input wire logic        t1_result_valid,
  input wire logic [15:0] t1_result,
  input wire logic        adc_sample,
  input wire logic [3:0]  adc_chan_sel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Two sampled cycles of one sampling window
  sequence s_window;
    adc_sample ##1 adc_sample;
  endsequence

  // Engine results carry the code in bits 14:3 only
  property p_foc_fmt; foc_result_valid |-> foc_result[15] == 1'b0 && foc_result[2:0] == 3'h0; endproperty
  a_foc_fmt: assert property (p_foc_fmt) else $error("motor engine result misaligned");
  property p_t1_fmt; t1_result_valid |-> t1_result[15] == 1'b0 && t1_result[2:0] == 3'h0; endproperty
  a_t1_fmt: assert property (p_t1_fmt) else $error("timer result misaligned");
  // One converter, so never two deliveries at once
  property p_one; !(foc_result_valid && t1_result_valid); endproperty
  a_one: assert property (p_one) else $error("two results delivered together");
  // A delivered result holds between deliveries
  property p_foc_hold; !foc_result_valid |-> $stable(foc_result); endproperty
  a_foc_hold: assert property (p_foc_hold) else $error("engine result moved");
  property p_t1_hold; !t1_result_valid |-> $stable(t1_result); endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer result moved");
  // Mux must not move while the input is being sampled
  property p_chan_hold; s_window |-> $stable(adc_chan_sel); endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved in window");
  // Fields of at least 3 ticks give windows far over 8 system cycles
  property p_samp_len; $rose(adc_sample) |-> adc_sample[*8]; endproperty
  a_samp_len: assert property (p_samp_len) else $error("sampling window too short");
  // Read data only reloads on a read address phase
  property p_rd_hold; !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_upper; hrdata[31:8] == 24'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("unused read bits set");
endmodule : adc_seq_checker

bind adc_sampling_sequencer adc_seq_checker i_adc_seq_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .foc_result_valid(foc_result_valid), .foc_result(foc_result),
  .t1_result_valid(t1_result_valid), .t1_result(t1_result), .adc_sample(adc_sample),
  .adc_chan_sel(adc_chan_sel)
);

// >>> adc_seq_pkg.sv
package adc_seq_pkg;

  // Converter geometry
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned NUM_CH      = 16;
  localparam int unsigned CH_W        = 4;
  localparam int unsigned TICKS_W     = 6;

  // Clock rates, used to derive the conversion tick
  localparam int unsigned SYS_CLK_MHZ  = 100;
  localparam int unsigned CONV_CLK_MHZ = 12;
  localparam logic [6:0]  TICK_MOD     = 7'(SYS_CLK_MHZ);
  localparam logic [6:0]  TICK_STEP    = 7'(CONV_CLK_MHZ);

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_DAC_CR   = 16'h4035;
  localparam logic [15:0] IDX_MASKH    = 16'h4036;
  localparam logic [15:0] IDX_MASKL    = 16'h4037;
  localparam logic [15:0] IDX_SCYC     = 16'h4038;
  localparam logic [15:0] IDX_CR       = 16'h4039;
  localparam logic [15:0] IDX_PH_SEL2  = 16'h4049;
  localparam logic [15:0] IDX_TRIG_CFG = 16'h4050;
  localparam logic [15:0] IDX_RES_BASE = 16'h0fd8;
  localparam logic [15:0] IDX_RES_LAST = 16'h0ff7;

  // Control register fields
  localparam int unsigned CR_ENABLE = 7;
  localparam int unsigned CR_BUSY   = 6;
  localparam int unsigned CR_RATIO  = 5;
  localparam int unsigned CR_ALIGN  = 2;
  localparam int unsigned CR_IE     = 1;
  localparam int unsigned CR_DONE   = 0;

  // Trigger configuration fields
  localparam int unsigned TC_FOC_EN   = 0;
  localparam int unsigned TC_SHUNT_LO = 1;
  localparam int unsigned TC_BUSV_SEL = 3;
  localparam int unsigned TC_T1_EN    = 4;
  localparam int unsigned TC_POS_SRC  = 5;
  localparam int unsigned TC_PH_MAP   = 6;

  // Reset values
  localparam logic [7:0]  CR_RST      = 8'h00;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [7:0]  SCYC_RST    = 8'h33;
  localparam logic [3:0]  SCYC_DAC_RST = 4'h3;
  localparam logic [3:0]  SCYC_PH_RST = 4'h0;
  localparam logic [6:0]  TRIG_RST    = 7'h00;

  // Shunt modes
  localparam logic [1:0] SHUNT_SINGLE = 2'h0;
  localparam logic [1:0] SHUNT_DUAL   = 2'h1;

  // Trigger request kinds
  localparam logic [1:0] FOC_IA   = 2'h0;
  localparam logic [1:0] FOC_IB   = 2'h1;
  localparam logic [1:0] FOC_IC   = 2'h2;
  localparam logic [1:0] T1_IBUS  = 2'h0;
  localparam logic [1:0] T1_U     = 2'h1;
  localparam logic [1:0] T1_V     = 2'h2;

  // Decode a 4-bit sampling field into conversion-clock cycles
  function automatic logic [TICKS_W-1:0] scyc_ticks(input logic [3:0] f);
    scyc_ticks = f[3] ? {f[2:0], 3'h7} : {3'h0, f[2:0]};
  endfunction : scyc_ticks

  // Place a code right-aligned or in bits 14:3, unused bits zero
  function automatic logic [15:0] align_code(input logic [CODE_W-1:0] c, input logic left);
    align_code = left ? {1'b0, c, 3'h0} : {4'h0, c};
  endfunction : align_code

endpackage : adc_seq_pkg

// >>> conv_tick_gen.sv
`timescale 1ns/1ps
module conv_tick_gen
  import adc_seq_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);

  logic [6:0] acc_q;
  logic [6:0] sum;

  // Fractional divider: 12 pulses every 100 cycles, jitter traded for one clock
  assign sum = acc_q + TICK_STEP;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      acc_q <= 7'h00;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (sum >= TICK_MOD);
      acc_q <= (sum >= TICK_MOD) ? sum - TICK_MOD : sum;
    end

endmodule : conv_tick_gen

// >>> sar_engine.sv
`timescale 1ns/1ps
module sar_engine
  import adc_seq_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               tick,
  input  wire logic               start,
  input  wire logic [CH_W-1:0]    chan,
  input  wire logic [TICKS_W-1:0] samp_ticks,
  input  wire logic               cmp_hi,
  output logic                    busy,
  output logic                    done,
  output logic [CODE_W-1:0]       code,
  output logic [CH_W-1:0]         chan_sel,
  output logic                    sampling,
  output logic [CODE_W-1:0]       trial
);

  logic [TICKS_W-1:0] cnt_q;
  logic [3:0]         bit_q;

  // Sample for the programmed ticks, then one bit trial per tick, MSB first
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      busy     <= 1'b0;
      done     <= 1'b0;
      code     <= '0;
      chan_sel <= '0;
      sampling <= 1'b0;
      trial    <= '0;
      cnt_q    <= '0;
      bit_q    <= 4'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy     <= 1'b1;
        sampling <= 1'b1;
        chan_sel <= chan;
        cnt_q    <= samp_ticks;
        trial    <= '0;
      end
      else if (busy && tick && sampling)
      begin
        // A zero field still samples for one tick
        if (cnt_q <= 6'h01)
        begin
          sampling <= 1'b0;
          bit_q    <= 4'(CODE_W - 1);
          trial    <= 12'h800;
        end
        else
          cnt_q <= cnt_q - 6'h01;
      end
      else if (busy && tick)
      begin
        if (bit_q == 4'h0)
        begin
          code  <= cmp_hi ? trial : trial & ~12'h001;
          busy  <= 1'b0;
          done  <= 1'b1;
        end
        else
        begin
          // Keep the bit if the input is above the trial level
          trial <= (cmp_hi ? trial : trial & ~(12'h001 << bit_q)) | (12'h001 << (bit_q - 4'h1));
          bit_q <= bit_q - 4'h1;
        end
      end
    end

endmodule : sar_engine
